// *** hdl/dpbr_block_ram.v ***
`timescale 1ns/100ps
`include "dpbr_map.vh"

module dpbr_block_ram #(
    parameter               FIRST_WIDTH  = `DPBR_WIDTH_DEF,
    parameter               SECOND_WIDTH = `DPBR_WIDTH_DEF,
    parameter [1:0]         FIRST_MODE   = `DPBR_MODE_RW,
    parameter [1:0]         SECOND_MODE  = `DPBR_MODE_RW,
    parameter [0:0]         SECOND_USED  = 1'h1,
    parameter [255:0]       INIT_STR_00  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_01  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_02  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_03  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_04  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_05  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_06  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_07  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_08  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_09  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_0a  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_0b  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_0c  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_0d  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_0e  = `DPBR_SEG_ZERO,
    parameter [255:0]       INIT_STR_0f  = `DPBR_SEG_ZERO
) (
    input  wire                    CLK,
    input  wire                    RST,
    input  wire                    FIRST_PORT_EN,
    input  wire                    FIRST_PORT_WE,
    input  wire [dpbr_aw(FIRST_WIDTH)-1:0]  FIRST_PORT_ADDR,
    input  wire [FIRST_WIDTH-1:0]  FIRST_PORT_WRITE_BUS,
    output wire [FIRST_WIDTH-1:0]  FIRST_PORT_READ_BUS,
    input  wire                    SECOND_PORT_EN,
    input  wire                    SECOND_PORT_WE,
    input  wire [dpbr_aw(SECOND_WIDTH)-1:0] SECOND_PORT_ADDR,
    input  wire [SECOND_WIDTH-1:0] SECOND_PORT_WRITE_BUS,
    output wire [SECOND_WIDTH-1:0] SECOND_PORT_READ_BUS,
    output wire                    COLLISION
);

    // =================================================================
    // Geometry
    // =================================================================

    // Address width for a port of width w over the whole array.
    function integer dpbr_aw;
        input integer w;
        integer depth;
        begin
            depth   = `DPBR_CELLS / w;
            dpbr_aw = 0;
            while ((1 << dpbr_aw) < depth) begin
                dpbr_aw = dpbr_aw + 1;
            end
        end
    endfunction

    // True for the widths that the array supports.
    function legal_width;
        input integer w;
        begin
            legal_width = (w == 1) || (w == 2) || (w == 4) ||
                          (w == 8) || (w == 16);
        end
    endfunction

    localparam SECOND_PORT_W = SECOND_WIDTH;
    localparam FAW           = dpbr_aw(FIRST_WIDTH);
    localparam SAW           = dpbr_aw(SECOND_WIDTH);
    localparam [0:0] FW_OK   = legal_width(FIRST_WIDTH);
    localparam [0:0] SW_OK   = legal_width(SECOND_WIDTH);

    // Strings stack upward: string k fills cells 256k+255..256k, and
    // Verilog zero-extends a short literal, padding absent high digits.
    localparam [4095:0] INIT_ALL = {
        INIT_STR_0f, INIT_STR_0e, INIT_STR_0d, INIT_STR_0c,
        INIT_STR_0b, INIT_STR_0a, INIT_STR_09, INIT_STR_08,
        INIT_STR_07, INIT_STR_06, INIT_STR_05, INIT_STR_04,
        INIT_STR_03, INIT_STR_02, INIT_STR_01, INIT_STR_00};

    // =================================================================
    // Operation decode
    // =================================================================

    // A read-only port never writes and a write-only port never reads.
    // An unsupported width disables its port altogether.
    wire a_live   = FIRST_PORT_EN & FW_OK;
    wire b_live   = SECOND_PORT_EN & SW_OK & SECOND_USED;
    wire a_wr_op  = a_live & FIRST_PORT_WE &
                    (FIRST_MODE != `DPBR_MODE_RO);
    wire a_rd_op  = a_live & ~FIRST_PORT_WE &
                    (FIRST_MODE != `DPBR_MODE_WO);
    wire b_wr_op  = b_live & SECOND_PORT_WE &
                    (SECOND_MODE != `DPBR_MODE_RO);
    wire b_rd_op  = b_live & ~SECOND_PORT_WE &
                    (SECOND_MODE != `DPBR_MODE_WO);

    // =================================================================
    // Mirror registers
    // =================================================================

    reg                    a_mirror_r;
    reg                    a_mirror_nxt;
    reg [FIRST_WIDTH-1:0]  a_wdata_r;
    reg [FIRST_WIDTH-1:0]  a_wdata_nxt;
    reg                    b_mirror_r;
    reg                    b_mirror_nxt;
    reg [SECOND_WIDTH-1:0] b_wdata_r;
    reg [SECOND_WIDTH-1:0] b_wdata_nxt;
    reg                    coll_r;
    reg                    coll_nxt;

    wire [FIRST_WIDTH-1:0]  a_cell_data;
    wire [SECOND_WIDTH-1:0] b_cell_data;

    // The mirror flag remembers whether the last operation of the port
    // was a write; it only moves when that port operates or on reset.
    always @* begin
        a_mirror_nxt = a_mirror_r;
        a_wdata_nxt  = a_wdata_r;
        if (a_wr_op) begin
            a_mirror_nxt = 1'b1;
            a_wdata_nxt  = FIRST_PORT_WRITE_BUS;
        end else if (a_rd_op) begin
            a_mirror_nxt = 1'b0;
        end
    end

    always @* begin
        b_mirror_nxt = b_mirror_r;
        b_wdata_nxt  = b_wdata_r;
        if (b_wr_op) begin
            b_mirror_nxt = 1'b1;
            b_wdata_nxt  = SECOND_PORT_WRITE_BUS;
        end else if (b_rd_op) begin
            b_mirror_nxt = 1'b0;
        end
    end

    // =================================================================
    // Same-cell write detection
    // =================================================================

    wire [31:0] a_lo = FIRST_PORT_ADDR * FIRST_WIDTH;
    wire [31:0] b_lo = SECOND_PORT_ADDR * SECOND_WIDTH;
    wire        overlap = (a_lo < b_lo + SECOND_WIDTH) &&
                          (b_lo < a_lo + FIRST_WIDTH);

    // Both ports writing shared cells on the same edge leaves those
    // cells undefined; each port still mirrors its own data.
    always @* begin
        coll_nxt = a_wr_op & b_wr_op & overlap;
    end

    // =================================================================
    // Sampling registers
    // =================================================================

    always @(posedge CLK) begin
        if (RST) begin
            a_mirror_r <= 1'b0;
            a_wdata_r  <= {FIRST_WIDTH{1'b0}};
            b_mirror_r <= 1'b0;
            b_wdata_r  <= {SECOND_WIDTH{1'b0}};
            coll_r     <= 1'b0;
        end else begin
            a_mirror_r <= a_mirror_nxt;
            a_wdata_r  <= a_wdata_nxt;
            b_mirror_r <= b_mirror_nxt;
            b_wdata_r  <= b_wdata_nxt;
            coll_r     <= coll_nxt;
        end
    end

    // =================================================================
    // Cell array
    // =================================================================

    // Address and data are taken by the array's own clocked process on
    // the same edge; there is no arbitration between the two ports.
    dpbr_cell_array #(
        .CELLS (`DPBR_CELLS),
        .WA    (FIRST_WIDTH),
        .WB    (SECOND_WIDTH),
        .AWA   (FAW),
        .AWB   (SAW),
        .INIT  (INIT_ALL)
    ) u_cells (
        .clk     (CLK),
        .rst     (RST),
        .a_rd_en (a_rd_op),
        .a_wr_en (a_wr_op),
        .a_addr  (FIRST_PORT_ADDR),
        .a_wdata (FIRST_PORT_WRITE_BUS),
        .a_rdata (a_cell_data),
        .b_rd_en (b_rd_op),
        .b_wr_en (b_wr_op),
        .b_addr  (SECOND_PORT_ADDR),
        .b_wdata (SECOND_PORT_WRITE_BUS),
        .b_rdata (b_cell_data)
    );

    // =================================================================
    // Outputs
    // =================================================================

    // Both legs of the select are registers set on the same edge, so
    // the bus never follows the address and holds between operations.
    assign FIRST_PORT_READ_BUS  = a_mirror_r ? a_wdata_r :
                                  a_cell_data;
    assign SECOND_PORT_READ_BUS = b_mirror_r ? b_wdata_r :
                                  b_cell_data;
    assign COLLISION            = coll_r;

endmodule // dpbr_block_ram

// *** hdl/dpbr_map.vh ***
`ifndef DPBR_MAP_VH
`define DPBR_MAP_VH

// =====================================================================
// Array geometry
// =====================================================================
`define DPBR_CELLS       4096
`define DPBR_SEG_BITS    256
`define DPBR_SEG_COUNT   16
`define DPBR_SEG_HEX     64

// =====================================================================
// Port function codes
// =====================================================================
`define DPBR_MODE_RW     2'h0
`define DPBR_MODE_RO     2'h1
`define DPBR_MODE_WO     2'h2

// =====================================================================
// Defaults and initial contents
// =====================================================================
`define DPBR_WIDTH_DEF   16
`define DPBR_SEG_ZERO    256'h0

`endif

// *** hdl/dpbr_cell_array.v ***
`timescale 1ns/100ps

// =====================================================================
// Bit-cell storage shared by both ports
// =====================================================================
module dpbr_cell_array #(
    parameter         CELLS = 4096,
    parameter         WA    = 16,
    parameter         WB    = 16,
    parameter         AWA   = 8,
    parameter         AWB   = 8,
    parameter [4095:0] INIT = 4096'h0
) (
    input  wire           clk,
    input  wire           rst,
    input  wire           a_rd_en,
    input  wire           a_wr_en,
    input  wire [AWA-1:0] a_addr,
    input  wire [WA-1:0]  a_wdata,
    output reg  [WA-1:0]  a_rdata,
    input  wire           b_rd_en,
    input  wire           b_wr_en,
    input  wire [AWB-1:0] b_addr,
    input  wire [WB-1:0]  b_wdata,
    output reg  [WB-1:0]  b_rdata
);

    reg     cells [0:CELLS-1];
    integer i;
    integer j;
    integer k;

    // Contents present at configuration; cell k takes bit k of INIT.
    initial begin
        for (i = 0; i < CELLS; i = i + 1) begin
            cells[i] = INIT[i];
        end
    end

    // Port B is applied after port A, so on overlapping writes the
    // cells end up with port B's bits; callers treat them as undefined.
    always @(posedge clk) begin
        if (a_wr_en) begin
            for (i = 0; i < WA; i = i + 1) begin
                cells[a_addr * WA + i] <= a_wdata[i];
            end
        end
        if (b_wr_en) begin
            for (i = 0; i < WB; i = i + 1) begin
                cells[b_addr * WB + i] <= b_wdata[i];
            end
        end
    end

    // Read data leave from registers that only change on a read or on reset.
    always @(posedge clk) begin
        if (rst) begin
            a_rdata <= {WA{1'b0}};
        end else if (a_rd_en) begin
            for (j = 0; j < WA; j = j + 1) begin
                a_rdata[j] <= cells[a_addr * WA + j];
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            b_rdata <= {WB{1'b0}};
        end else if (b_rd_en) begin
            for (k = 0; k < WB; k = k + 1) begin
                b_rdata[k] <= cells[b_addr * WB + k];
            end
        end
    end

endmodule // dpbr_cell_array

// *** dv/dpbr_user_port.sv ***
`timescale 1ns/100ps
// =====================================================================
// User logic driving one RAM port
// =====================================================================
module dpbr_user_port #(
    parameter W  = 16,
    parameter AW = 8
) (
    input  wire           clk,
    output logic          en,
    output logic          we,
    output logic [AW-1:0] addr,
    output logic [W-1:0]  data
);
    initial begin
        en = 1'b0;
        we = 1'b0;
        addr = '0;
        data = '0;
    end

    // An idle port inverts its buses so a stale value is never trusted.
    task automatic op(input logic e, w, input logic [AW-1:0] a,
                      input logic [W-1:0] d);
        en = e;
        we = w & e;
        addr = e ? a : ~addr;
        data = e ? d : ~data;
        @(posedge clk);
        #1;
    endtask
endmodule // dpbr_user_port

// *** dv/dpbr_block_ram_chk.sv ***
`timescale 1ns/100ps
// =====================================================================
// Port behaviour checker
// =====================================================================
module dpbr_chk #(
    parameter FIRST_WIDTH  = 16,
    parameter SECOND_WIDTH = 4
) (
    input wire                    CLK,
    input wire                    RST,
    input wire                    FIRST_PORT_EN,
    input wire                    FIRST_PORT_WE,
    input wire [$clog2(4096/FIRST_WIDTH)-1:0] FIRST_PORT_ADDR,
    input wire [FIRST_WIDTH-1:0]  FIRST_PORT_WRITE_BUS,
    input wire [FIRST_WIDTH-1:0]  FIRST_PORT_READ_BUS,
    input wire                    SECOND_PORT_EN,
    input wire                    SECOND_PORT_WE,
    input wire [$clog2(4096/SECOND_WIDTH)-1:0] SECOND_PORT_ADDR,
    input wire [SECOND_WIDTH-1:0] SECOND_PORT_WRITE_BUS,
    input wire [SECOND_WIDTH-1:0] SECOND_PORT_READ_BUS,
    input wire                    COLLISION
);
    localparam R = FIRST_WIDTH / SECOND_WIDTH;
    wire wr_a = FIRST_PORT_EN & FIRST_PORT_WE;
    wire wr_b = SECOND_PORT_EN & SECOND_PORT_WE;
    wire coll = !RST & wr_a & wr_b & (SECOND_PORT_ADDR / R == FIRST_PORT_ADDR);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence wr_a_s;
        wr_a & !coll;
    endsequence
    sequence rd_a_s;
        FIRST_PORT_EN & !FIRST_PORT_WE
            & (FIRST_PORT_ADDR == $past(FIRST_PORT_ADDR));
    endsequence
    sequence rd_b_s;
        SECOND_PORT_EN & !SECOND_PORT_WE
            & (SECOND_PORT_ADDR / R == $past(FIRST_PORT_ADDR));
    endsequence
    a_first_mirror: assert property (
        wr_a |=> FIRST_PORT_READ_BUS == $past(FIRST_PORT_WRITE_BUS))
        else $error("first port write not mirrored");
    a_second_mirror: assert property (
        wr_b |=> SECOND_PORT_READ_BUS == $past(SECOND_PORT_WRITE_BUS))
        else $error("second port write not mirrored");
    a_first_hold: assert property (
        !FIRST_PORT_EN |=> $stable(FIRST_PORT_READ_BUS))
        else $error("first port output moved while idle");
    a_second_hold: assert property (
        !SECOND_PORT_EN |=> $stable(SECOND_PORT_READ_BUS))
        else $error("second port output moved while idle");
    a_own_read: assert property (
        wr_a_s ##1 rd_a_s |=>
            FIRST_PORT_READ_BUS == $past(FIRST_PORT_WRITE_BUS, 2))
        else $error("first port read after write wrong");
    a_cross_read: assert property (
        wr_a_s ##1 rd_b_s |=> SECOND_PORT_READ_BUS == SECOND_WIDTH'(
            $past(FIRST_PORT_WRITE_BUS, 2)
            >> ($past(SECOND_PORT_ADDR) % R * SECOND_WIDTH)))
        else $error("cross port read wrong");
    a_collision_flag: assert property (
        1 |=> COLLISION == $past(coll))
        else $error("collision flag wrong");
    a_collision_mirror: assert property (
        coll |=> (FIRST_PORT_READ_BUS == $past(FIRST_PORT_WRITE_BUS))
            && (SECOND_PORT_READ_BUS == $past(SECOND_PORT_WRITE_BUS)))
        else $error("collision outputs not mirrored");
endmodule // dpbr_chk

bind dpbr_block_ram dpbr_chk #(
    .FIRST_WIDTH (FIRST_WIDTH),
    .SECOND_WIDTH(SECOND_WIDTH)
) chk_u (
    .CLK(CLK), .RST(RST), .FIRST_PORT_EN(FIRST_PORT_EN),
    .FIRST_PORT_WE(FIRST_PORT_WE), .FIRST_PORT_ADDR(FIRST_PORT_ADDR),
    .FIRST_PORT_WRITE_BUS(FIRST_PORT_WRITE_BUS),
    .FIRST_PORT_READ_BUS(FIRST_PORT_READ_BUS),
    .SECOND_PORT_EN(SECOND_PORT_EN), .SECOND_PORT_WE(SECOND_PORT_WE),
    .SECOND_PORT_ADDR(SECOND_PORT_ADDR),
    .SECOND_PORT_WRITE_BUS(SECOND_PORT_WRITE_BUS),
    .SECOND_PORT_READ_BUS(SECOND_PORT_READ_BUS), .COLLISION(COLLISION)
);

// *** dv/dpbr_block_ram_tb.sv ***
`timescale 1ns/100ps
// =====================================================================
// Bench with a cell-level model of the shared array
// =====================================================================
module dpbr_block_ram_tb;
    localparam [255:0] INIT0 =
        256'h0f1e2d3c4b5a69788796a5b4c3d2e1f00112233445566778899aabbccddeeff;
    localparam [255:0] INIT1 = 256'h5a;
    localparam int     FW    = 16;
    localparam int     SW    = 4;
    localparam int     FAW   = 8;
    localparam int     SAW   = 10;
    logic          CLK = 1'b0;
    logic          RST = 1'b1;
    logic          a_en, a_we, b_en, b_we, coll;
    logic [7:0]    a_ad, aa;
    logic [9:0]    b_ad;
    logic [15:0]   a_wd, a_rd, xa, ka, x, y;
    logic [15:0]   r = 16'h005c;
    logic [3:0]    b_wd, b_rd, xb, kb;
    logic [4095:0] m, u;
    int            fails, checks_done, cyc, i;

    dpbr_block_ram #(
        .FIRST_WIDTH (FW),
        .SECOND_WIDTH(SW),
        .INIT_STR_00 (INIT0),
        .INIT_STR_01 (INIT1),
        .INIT_STR_0f (~INIT0)
    ) dut_u (
        .CLK(CLK), .RST(RST), .FIRST_PORT_EN(a_en), .FIRST_PORT_WE(a_we),
        .FIRST_PORT_ADDR(a_ad), .FIRST_PORT_WRITE_BUS(a_wd),
        .FIRST_PORT_READ_BUS(a_rd), .SECOND_PORT_EN(b_en),
        .SECOND_PORT_WE(b_we), .SECOND_PORT_ADDR(b_ad),
        .SECOND_PORT_WRITE_BUS(b_wd), .SECOND_PORT_READ_BUS(b_rd),
        .COLLISION(coll)
    );
    dpbr_user_port #(.W(FW), .AW(FAW)) pa_u (.clk(CLK), .en(a_en),
        .we(a_we), .addr(a_ad), .data(a_wd));
    dpbr_user_port #(.W(SW), .AW(SAW)) pb_u (.clk(CLK), .en(b_en),
        .we(b_we), .addr(b_ad), .data(b_wd));

    always #10 CLK = ~CLK;

    function automatic logic [15:0] nxt();
        r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
        return r;
    endfunction

    task automatic check(input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One edge on both ports; cells hit by a dual write are masked out.
    task automatic step(input logic ea, wa, input logic [7:0] a,
        input logic [15:0] da, input logic eb, wb, input logic [9:0] ab,
        input logic [3:0] db);
        logic c;
        c = ea & wa & eb & wb & (ab[9:2] == a);
        if (ea) begin
            xa = wa ? da : m[a*16 +: 16];
            ka = wa ? 16'h0 : u[a*16 +: 16];
        end
        if (eb) begin
            xb = wb ? db : m[ab*4 +: 4];
            kb = wb ? 4'h0 : u[ab*4 +: 4];
        end
        if (ea & wa) begin
            m[a*16 +: 16] = da;
            u[a*16 +: 16] = 16'h0;
        end
        if (eb & wb) begin
            m[ab*4 +: 4] = db;
            u[ab*4 +: 4] = {4{c}};
        end
        fork
            pa_u.op(ea, wa, a, da);
            pb_u.op(eb, wb, ab, db);
        join
        check(a_rd & ~ka, xa & ~ka);
        check({12'h0, b_rd & ~kb}, {12'h0, xb & ~kb});
        check({15'h0, coll}, {15'h0, c});
    endtask

    always @(posedge CLK) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        m = {~INIT0, 3328'h0, INIT1, INIT0};
        u = '0;
        xa = '0;
        ka = '0;
        xb = '0;
        kb = '0;
        repeat (8) @(posedge CLK);
        #1;
        RST = 1'b0;
        for (i = 0; i < 256; i++) begin
            step(1, 0, i[7:0], 0, 0, 0, 0, 0);
        end
        $display("preload test done");
        step(1, 1, 8'hff, 16'hbeef, 0, 0, 0, 0);
        step(1, 0, 8'hff, 0, 1, 0, 10'h3ff, 0);
        step(1, 1, 8'hff, 16'h1234, 1, 0, 10'h3fc, 0);
        $display("top boundary test done");
        for (i = 0; i < 600; i++) begin
            x = nxt();
            y = nxt();
            aa = x[15] ? x[7:0] : {6'h0, x[1:0]};
            step(x[3] | x[4], x[2], aa, y, x[5] | x[6], x[7],
                x[14] ? {y[7:0], x[9:8]} : {aa, x[9:8]}, y[15:12]);
        end
        $display("random traffic test done");
        finish_test();
    end
endmodule // dpbr_block_ram_tb
